//--- dv/psc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module psc_properties (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // register bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  // console and storage
  input wire logic o_halted,
  input wire logic o_stor_req,
  input wire logic o_stor_we,
  input wire logic [12:0] o_stor_addr,
  input wire logic [27:0] o_stor_wdata,
  input wire logic i_stor_ack,
  input wire logic [27:0] i_stor_rdata
);
  logic [27:0] rd_q;
  logic [12:0] ra_q;
  logic rd_acc;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  assign rd_acc = i_hsel && i_htrans[1] && i_hready && !i_hwrite;
  ////////////////////////////////////////////////////////////////////////
  // last word read from storage and its address
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_q <= 28'h0000000;
      ra_q <= 13'h0000;
    end
    else if (o_stor_req && !o_stor_we && i_stor_ack)
    begin
      rd_q <= i_stor_rdata;
      ra_q <= o_stor_addr;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  halt_idle_a: assert property (o_halted |-> !o_stor_req)
    else $error("storage request while halted");
  restart_fetch_a: assert property ($fell(o_halted) |->
    ##[0:2] (o_stor_req && !o_stor_we))
    else $error("no fetch after restart");
  req_stand_a: assert property (o_stor_req && !i_stor_ack |=>
    o_stor_req && $stable(o_stor_addr) && $stable(o_stor_wdata))
    else $error("storage request not held");
  read_first_a: assert property ($rose(o_stor_req) |-> !o_stor_we)
    else $error("request opened as a write");
  write_cause_a: assert property ($rose(o_stor_we) |-> $past(i_stor_ack))
    else $error("write not preceded by a read answer");
  write_end_a: assert property (o_stor_req && o_stor_we && i_stor_ack
    |=> !o_stor_req && !o_stor_we)
    else $error("write request not released");
  link_addr_a: assert property (o_stor_req && o_stor_we |->
    o_stor_addr == ra_q)
    else $error("link word written to another address");
  link_keep_a: assert property (o_stor_req && o_stor_we |->
    o_stor_wdata[27:15] == rd_q[27:15])
    else $error("link write lost upper bits");
  p_sign_a: assert property (rd_acc && i_haddr[7:0] == 8'h08 |=>
    o_hrdata[31:24] == 8'h00 && o_hrdata[23:15] == {9{o_hrdata[14]}})
    else $error("address counter read without sign extension");
endmodule : psc_properties
`default_nettype wire

//--- dv/psc_store_model.sv
`timescale 1ns/1ps
`default_nettype none
module psc_store_model (
  // request from the block
  input wire logic i_ref_clk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [12:0] i_addr,
  input wire logic [27:0] i_wdata,
  input wire logic [3:0] i_delay,
  // answer to the block
  output logic o_ack,
  output logic [27:0] o_rdata
);
  logic [27:0] mem [8192];
  int waited = 0;
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 28'h0000000;
  end
  // one ack pulse per request; read data changes every idle cycle
  always @(posedge i_ref_clk)
  begin
    if (o_ack || !i_req)
    begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      waited <= 0;
    end
    else if (waited < int'(i_delay))
      waited <= waited + 1;
    else
    begin
      o_ack <= 1'b1;
      if (i_we)
        mem[i_addr] <= i_wdata;
      else
        o_rdata <= mem[i_addr];
    end
  end
endmodule : psc_store_model
`default_nettype wire

//--- dv/tb_program_sequence_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_program_sequence_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [5:0] keys = 6'h00;
  logic hready, hresp, halted, req, we, ack;
  logic [31:0] hrdata, q;
  logic [12:0] saddr;
  logic [27:0] wdata, rdata, tgt;
  logic [31:0] rnd = 32'h00008014;
  logic [31:0] dr = 32'h00008014;
  int miscompares = 0;
  int checks_done = 0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [14:0] oc_inc(input logic [14:0] p);
    logic [15:0] s;
    s = {1'b0, p} + 16'h0001;
    return s[14:0] + {14'h0000, s[15]};
  endfunction : oc_inc
  function automatic logic [23:0] ins(input logic [5:0] o,
    input logic [2:0] s, input logic [14:0] m);
    return {o, s, m};
  endfunction : ins
  always #5 clk = ~clk;
  always @(posedge clk) dr <= lfsr(dr);
  psc_top dut (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_jump_key(keys), .o_halted(halted), .o_stor_req(req),
    .o_stor_we(we), .o_stor_addr(saddr), .o_stor_wdata(wdata),
    .i_stor_ack(ack), .i_stor_rdata(rdata)
  );
  psc_store_model u_mem (
    .i_ref_clk(clk), .i_req(req), .i_we(we), .i_addr(saddr),
    .i_wdata(wdata), .i_delay(dr[3:0]), .o_ack(ack), .o_rdata(rdata)
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
    input string n);
    ahb(1'b0, a, 32'h00000000);
    chk(n, e, q);
  endtask : rdchk
  task automatic ld(input logic [12:0] a, input logic [23:0] w);
    rnd = lfsr(rnd);
    u_mem.mem[a] = {rnd[3:0], w};
  endtask : ld
  task automatic hwait();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (halted !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("halted", 32'h00000001, {31'h00000000, halted});
  endtask : hwait
  task automatic go(input logic [14:0] p);
    wr(8'h08, {17'h00000, p});
    wr(8'h00, 32'h00000001);
    hwait();
  endtask : go
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rdchk(8'h0C, 32'h00000001, "status");
    wr(8'h04, 32'h0000003F);
    rdchk(8'h04, 32'h0000003F, "state");
    wr(8'h04, 32'h00000000);
    wr(8'h24, 32'h00000ABC);
    rdchk(8'h24, 32'h00000ABC, "pix");
    wr(8'h18, 32'h0000FFFF);
    rdchk(8'h18, 32'h00000000, "unmapped");
    // counter wrap, key clear, key set, link, halt
    ld(13'h1FFF, ins(6'h00, 3'h1, 15'h0600));
    ld(13'h0600, ins(6'h00, 3'h0, 15'h0111));
    ld(13'h0000, ins(6'h00, 3'h0, 15'h0333));
    ld(13'h0001, ins(6'h00, 3'h2, 15'h0200));
    ld(13'h0002, ins(6'h00, 3'h0, 15'h0222));
    ld(13'h0200, ins(6'h00, 3'h7, 15'h0300));
    ld(13'h0300, {6'h3F, rnd[17:0]});
    ld(13'h0301, ins(6'h00, 3'h0, 15'h7FFE));
    tgt = u_mem.mem[13'h0300];
    keys <= 6'h02;
    go(15'h7FFF);
    rdchk(8'h08, 32'h00FFFFFE, "p");
    chk("link", {4'h0, tgt[27:15], oc_inc(15'h0200)},
      {4'h0, u_mem.mem[13'h0300]});
    rdchk(8'h10, 32'h00000301, "s");
    rdchk(8'h14, {4'h0, u_mem.mem[13'h0301]}, "z");
    for (int k = 1; k <= 6; k++)
    begin
      ld(13'h0400, ins(6'h00, k[2:0], 15'h0500));
      ld(13'h0500, ins(6'h00, 3'h0, 15'h0055));
      ld(13'h0401, ins(6'h00, 3'h0, 15'h0044));
      keys <= rnd[5:0];
      repeat (5) @(posedge clk);
      go(15'h0400);
      rdchk(8'h08, keys[k-1] ? 32'h55 : 32'h44, "key");
    end
    // restricted state: halt refused while looping
    ld(13'h0700, ins(6'h2D, 3'h0, 15'h0000));
    ld(13'h0701, ins(6'h00, 3'h0, 15'h0123));
    ld(13'h0702, ins(6'h00, 3'h6, 15'h0701));
    keys <= 6'h20;
    wr(8'h08, 32'h00000700);
    wr(8'h00, 32'h00000081);
    repeat (200) @(posedge clk);
    wr(8'h08, 32'h00000999);
    rdchk(8'h0C, 32'h00000002, "refused");
    rdchk(8'h04, 32'h00000040, "state");
    wr(8'h00, 32'h00000000);
    hwait();
    rdchk(8'h08, 32'h00000123, "p");
    wr(8'h0C, 32'h00000002);
    rdchk(8'h0C, 32'h00000001, "status");
    ld(13'h0800, ins(6'h2D, 3'h4, 15'h0000));
    ld(13'h0801, ins(6'h00, 3'h0, 15'h0000));
    go(15'h0800);
    rdchk(8'h04, 32'h00000000, "state");
    end_sim();
  end
endmodule : tb_program_sequence_control
bind psc_top psc_properties u_prop (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_hrdata(o_hrdata), .o_halted(o_halted), .o_stor_req(o_stor_req),
  .o_stor_we(o_stor_we), .o_stor_addr(o_stor_addr),
  .o_stor_wdata(o_stor_wdata), .i_stor_ack(i_stor_ack),
  .i_stor_rdata(i_stor_rdata)
);
`default_nettype wire

//--- inc/psc_defines.svh
// What this block does
// - the program address counter is a 15-bit one's complement counter.
// - code 00.0 halts, and a restart fetches from the address field.
// - codes 00.1 to 00.6 jump to the address field if that key is set.
// - code 00.7 stores the address plus one, then goes on at target + 1.
// - the top stage of a signed quantity is its sign, 1 meaning negative.
// - a short signed operand put in a wider register copies its sign up.
// - a 3-bit operand selector picks the group for operand addresses.
// - a 3-bit fetch selector picks the group for instruction fetches.
// - code 55.0 sends operands to the fetch group, 55.4 sends them back.
// - a group spans a 32,768-word space; a state number picks one of 8.
// - pages of 2,048 words in quarter pages, indexed by 12-bit entries.
// - in the restricted state, halt and I/O codes are refused.
// - a 13-bit address register holds the word being referenced.
// - a 28-bit data register catches each read and feeds each write.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_AW 15
`define PSC_SW 13
`define PSC_ZW 28
`define PSC_DW 24
`define PSC_PIW 12
`define PSC_QPAGE_LG 9
`define PSC_OP_HI 23
`define PSC_OP_LO 18
`define PSC_SUB_HI 17
`define PSC_SUB_LO 15
`define PSC_OP_JUMP 6'h00
`define PSC_OP_RELOC 6'h2D
`define PSC_IO_HI 3'h7
`define PSC_SUB_HALT 3'h0
`define PSC_SUB_LINK 3'h7
`define PSC_SUB_RIS 3'h0
`define PSC_SUB_ROS 3'h4
`define PSC_OFS_CTRL 8'h00
`define PSC_OFS_STATE 8'h04
`define PSC_OFS_PADDR 8'h08
`define PSC_OFS_STAT 8'h0C
`define PSC_OFS_SADDR 8'h10
`define PSC_OFS_ZDATA 8'h14
`define PSC_OFS_PIX 8'h20
`define PSC_B_GO 0
`define PSC_B_RESTR 7
`define PSC_B_HALTED 0
`define PSC_B_REFUSED 1
`define PSC_B_RIS 6
`endif

//--- inc/psc_pkg.sv
package psc_pkg;
  typedef enum logic [2:0] {
    PSC_HALT, PSC_ISSUE, PSC_FWAIT, PSC_EXEC, PSC_LRD, PSC_LWR
  } psc_state_t;
  typedef logic [14:0] psc_addr_t;
  typedef logic [2:0] psc_grp_t;
endpackage : psc_pkg

//--- inc/psc_reloc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psc_reloc_if;
  psc_pkg::psc_grp_t grp;
  psc_pkg::psc_addr_t laddr;
  logic [12:0] paddr;
  logic wr;
  psc_pkg::psc_grp_t wgrp;
  logic [11:0] wdata;
  psc_pkg::psc_grp_t rgrp;
  logic [11:0] rdata;
  modport ctl (output grp, laddr, wr, wgrp, wdata, rgrp,
               input paddr, rdata);
  modport map (input grp, laddr, wr, wgrp, wdata, rgrp,
               output paddr, rdata);
endinterface : psc_reloc_if
`default_nettype wire

//--- src/psc_oc_add.sv
`timescale 1ns/1ps
`default_nettype none
module psc_oc_add #(
  parameter int W = 15
) (
  // operands
  input wire logic [W-1:0] i_a,
  input wire logic [W-1:0] i_b,
  // sum
  output logic [W-1:0] o_sum
);
  logic [W:0] raw;
  generate
    if (W < 2)
    begin : g_bad
      $error("psc_oc_add: width too small");
    end
  endgenerate
  // end-around carry gives modulus 2**W - 1
  always_comb
  begin
    raw = {1'b0, i_a} + {1'b0, i_b};
    o_sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
  end
endmodule : psc_oc_add
`default_nettype wire

//--- src/psc_reloc.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"
module psc_reloc #(
  parameter int GROUPS = 7
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // map side
  psc_reloc_if.map rif
);
  import psc_pkg::*;
  logic [`PSC_PIW-1:0] pix [1:GROUPS];
  logic [`PSC_PIW-1:0] next_pix [1:GROUPS];
  logic [`PSC_PIW+`PSC_QPAGE_LG:0] sum;
  generate
    if (GROUPS != 7)
    begin : g_bad
      $error("psc_reloc: group selector serves seven groups");
    end
  endgenerate
  // group 0 is absolute; groups 1..7 add a quarter-page base
  always_comb
  begin
    sum = '0;
    if (rif.grp != 3'h0)
      sum = {1'b0, pix[rif.grp], {`PSC_QPAGE_LG{1'b0}}};
    sum = sum + {{(`PSC_PIW-5){1'b0}}, rif.laddr};
    rif.paddr = sum[`PSC_SW-1:0];
    rif.rdata = (rif.rgrp == 3'h0) ? '0 : pix[rif.rgrp];
  end
  generate
    for (genvar g = 1; g <= GROUPS; g++)
    begin : g_pix
      always_comb
      begin
        next_pix[g] = pix[g];
        if (rif.wr && rif.wgrp == 3'(g))
          next_pix[g] = rif.wdata;
      end
      always_ff @(posedge i_ref_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
          pix[g] <= '0;
        else if (i_ce)
          pix[g] <= next_pix[g];
      end
    end
  endgenerate
endmodule : psc_reloc
`default_nettype wire

//--- src/psc_top.sv
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"
module psc_top (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // console
  input wire logic [5:0] i_jump_key,
  output logic o_halted,
  // core storage
  output logic o_stor_req,
  output logic o_stor_we,
  output logic [`PSC_SW-1:0] o_stor_addr,
  output logic [`PSC_ZW-1:0] o_stor_wdata,
  input wire logic i_stor_ack,
  input wire logic [`PSC_ZW-1:0] i_stor_rdata
);
  import psc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // sign extension of a 15-bit field into a data word
  function automatic logic [`PSC_DW-1:0] sext(input psc_addr_t v);
    sext = {{(`PSC_DW-`PSC_AW){v[`PSC_AW-1]}}, v};
  endfunction : sext

  ////////////////////////////////////////////////////////////////////////
  // jump key synchroniser: a change counts once stages two and three agree
  logic [5:0] k1, k2, k3, key;
  logic [5:0] next_key;
  always_comb
  begin
    next_key = (key & (k2 ^ k3)) | (k3 & ~(k2 ^ k3));
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      k1 <= '0;
      k2 <= '0;
      k3 <= '0;
      key <= '0;
    end
    else if (i_ce)
    begin
      k1 <= i_jump_key;
      k2 <= k1;
      k3 <= k2;
      key <= next_key;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  psc_state_t st, next_st;
  psc_addr_t pc, next_pc;
  logic [`PSC_SW-1:0] saddr, next_saddr;
  logic [`PSC_ZW-1:0] zdata, next_zdata;
  logic req, next_req, we, next_we;
  psc_grp_t osel, next_osel, isel, next_isel;
  logic operands_use_fetch_group, next_ris, restr, next_restr;
  logic refused, next_refused;
  psc_addr_t pc_inc, m_inc, m;
  logic [5:0] op;
  logic [2:0] sub;
  logic go, ref_clr;

  // ahb register side
  logic ap_valid, next_ap_valid, ap_write, next_ap_write;
  logic [7:0] ap_addr, next_ap_addr;
  logic [31:0] rdata, next_rdata;
  logic wr_hit;

  psc_reloc_if rif ();

  psc_oc_add #(.W(`PSC_AW)) u_pinc (
    .i_a(pc),
    .i_b(15'h0001),
    .o_sum(pc_inc)
  );
  psc_oc_add #(.W(`PSC_AW)) u_minc (
    .i_a(m),
    .i_b(15'h0001),
    .o_sum(m_inc)
  );
  psc_reloc #(.GROUPS(7)) u_reloc (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .rif(rif)
  );

  assign op = zdata[`PSC_OP_HI:`PSC_OP_LO];
  assign sub = zdata[`PSC_SUB_HI:`PSC_SUB_LO];
  assign m = zdata[`PSC_AW-1:0];
  assign wr_hit = ap_valid && ap_write;
  assign go = wr_hit && ap_addr == `PSC_OFS_CTRL && i_hwdata[`PSC_B_GO];
  assign ref_clr = wr_hit && ap_addr == `PSC_OFS_STAT &&
                   i_hwdata[`PSC_B_REFUSED];

  // fetches use the fetch group; operands use the selected group
  always_comb
  begin
    rif.laddr = (st == PSC_EXEC) ? m : pc;
    rif.grp = isel;
    if (st == PSC_EXEC && !operands_use_fetch_group)
      rif.grp = osel;
    rif.wr = wr_hit && ap_addr[7:5] == 3'h1;
    rif.wgrp = ap_addr[4:2];
    rif.wdata = i_hwdata[`PSC_PIW-1:0];
    rif.rgrp = i_haddr[4:2];
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb
  begin
    next_st = st;
    next_pc = pc;
    next_saddr = saddr;
    next_zdata = zdata;
    next_req = req;
    next_we = we;
    next_ris = operands_use_fetch_group;
    next_refused = refused;
    next_osel = osel;
    next_isel = isel;
    next_restr = restr;
    if (ref_clr)
      next_refused = 1'b0;
    case (st)
      PSC_HALT:
      begin
        // restart resumes at the counter, loaded from the halt address
        if (go)
          next_st = PSC_ISSUE;
      end
      PSC_ISSUE:
      begin
        next_saddr = rif.paddr;
        next_req = 1'b1;
        next_we = 1'b0;
        next_st = PSC_FWAIT;
      end
      PSC_FWAIT:
      begin
        if (i_stor_ack)
        begin
          next_req = 1'b0;
          next_zdata = i_stor_rdata;
          next_st = PSC_EXEC;
        end
      end
      PSC_EXEC:
      begin
        next_pc = pc_inc;
        next_st = PSC_ISSUE;
        if (op == `PSC_OP_JUMP)
        begin
          if (sub == `PSC_SUB_HALT)
          begin
            if (restr)
              next_refused = 1'b1;
            else
            begin
              next_pc = m;
              next_st = PSC_HALT;
            end
          end
          else if (sub == `PSC_SUB_LINK)
          begin
            next_saddr = rif.paddr;
            next_req = 1'b1;
            next_st = PSC_LRD;
          end
          else if (key[sub - 3'h1])
            next_pc = m;
          // a clear key keeps the incremented address
        end
        else if (op == `PSC_OP_RELOC)
        begin
          if (sub == `PSC_SUB_RIS)
            next_ris = 1'b1;
          else if (sub == `PSC_SUB_ROS)
            next_ris = 1'b0;
        end
        else if (restr && op[5:3] == `PSC_IO_HI)
          next_refused = 1'b1;
      end
      PSC_LRD:
      begin
        // zdata keeps the link instruction's target until the read answer, which replaces it with the link word
        if (i_stor_ack)
        begin
          next_zdata = {i_stor_rdata[`PSC_ZW-1:`PSC_AW], pc};
          next_we = 1'b1;
          next_st = PSC_LWR;
        end
      end
      PSC_LWR:
      begin
        if (i_stor_ack)
        begin
          next_req = 1'b0;
          next_we = 1'b0;
          next_st = PSC_ISSUE;
        end
      end
      default:
      begin
        next_st = PSC_HALT;
      end
    endcase
    // pc already holds target + 1 while the link word is written
    if (st == PSC_LWR && i_stor_ack)
      next_pc = pc;
    if (st == PSC_LRD && i_stor_ack)
      next_pc = m_inc;
    if (st == PSC_HALT && wr_hit)
    begin
      if (ap_addr == `PSC_OFS_PADDR)
        next_pc = i_hwdata[`PSC_AW-1:0];
      if (ap_addr == `PSC_OFS_STATE)
      begin
        next_osel = i_hwdata[2:0];
        next_isel = i_hwdata[5:3];
      end
    end
    if (wr_hit && ap_addr == `PSC_OFS_CTRL)
      next_restr = i_hwdata[`PSC_B_RESTR];
    // a refusal in the clearing cycle still lands
    if (st == PSC_EXEC && restr &&
        ((op == `PSC_OP_JUMP && sub == `PSC_SUB_HALT) ||
         op[5:3] == `PSC_IO_HI))
      next_refused = 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st <= PSC_HALT;
      pc <= '0;
      saddr <= '0;
      zdata <= '0;
      req <= 1'b0;
      we <= 1'b0;
      operands_use_fetch_group <= 1'b0;
      refused <= 1'b0;
      osel <= '0;
      isel <= '0;
      restr <= 1'b0;
    end
    else if (i_ce)
    begin
      st <= next_st;
      pc <= next_pc;
      saddr <= next_saddr;
      zdata <= next_zdata;
      req <= next_req;
      we <= next_we;
      operands_use_fetch_group <= next_ris;
      refused <= next_refused;
      osel <= next_osel;
      isel <= next_isel;
      restr <= next_restr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  always_comb
  begin
    next_ap_valid = 1'b0;
    next_ap_write = ap_write;
    next_ap_addr = ap_addr;
    next_rdata = rdata;
    if (i_hready)
    begin
      next_ap_valid = i_hsel && i_htrans[1];
      next_ap_write = i_hwrite;
      next_ap_addr = {i_haddr[7:2], 2'b00};
      next_rdata = '0;
      if (i_hsel && i_htrans[1] && !i_hwrite)
      begin
        case ({i_haddr[7:2], 2'b00})
          `PSC_OFS_CTRL: next_rdata[`PSC_B_RESTR] = restr;
          `PSC_OFS_STATE:
            next_rdata[`PSC_B_RIS:0] = {operands_use_fetch_group, isel, osel};
          `PSC_OFS_PADDR: next_rdata[`PSC_DW-1:0] = sext(pc);
          `PSC_OFS_STAT:
            next_rdata[1:0] = {refused, st == PSC_HALT};
          `PSC_OFS_SADDR: next_rdata[`PSC_SW-1:0] = saddr;
          `PSC_OFS_ZDATA: next_rdata[`PSC_ZW-1:0] = zdata;
          default:
          begin
            if (i_haddr[7:5] == 3'h1)
              next_rdata[`PSC_PIW-1:0] = pix_rd(i_haddr[4:2]);
          end
        endcase
      end
    end
  end

  // page index readback goes through the map's read port
  function automatic logic [`PSC_PIW-1:0] pix_rd(input psc_grp_t g);
    pix_rd = (g == rif.rgrp) ? rif.rdata : '0;
  endfunction : pix_rd

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= '0;
      rdata <= '0;
    end
    else if (i_ce)
    begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      rdata <= next_rdata;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata;
  assign o_halted = (st == PSC_HALT);
  assign o_stor_req = req;
  assign o_stor_we = we;
  assign o_stor_addr = saddr;
  assign o_stor_wdata = zdata;
endmodule : psc_top
`default_nettype wire
